// file: inc/lmf_cfg.svh
// Constants of the multiplexed LCD frame timing block
`ifndef LMF_CFG_SVH
`define LMF_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LMF_IDX_W        10
`define LMF_IDX_RAM_LAST 10'h03f
`define LMF_IDX_MODE     10'h0dc
`define LMF_IDX_PAGE     10'h0e0
`define LMF_IDX_STATUS   10'h0e1
`define LMF_ADDR_LSB     2
`define LMF_ADDR_MSB     11

// ****************************************************************
// Mode control register fields and reset values
// ****************************************************************
`define LMF_MODE_RST     8'h00
`define LMF_MODE_MASK    8'hfb
`define LMF_BIT_SIXTEEN_ROW_SELECT    7
`define LMF_BIT_ELEVEN_ROW_SELECT    6
`define LMF_HF_HI        5
`define LMF_HF_LO        3
`define LMF_LF_HI        1
`define LMF_LF_LO        0

// ****************************************************************
// Clock source codes and internal divisors (minus one)
// ****************************************************************
`define LMF_HF_OFF       3'h0
`define LMF_HF_AUX       3'h1
`define LMF_HF_DIV32     3'h3
`define LMF_HF_DIV64     3'h4
`define LMF_HF_DIV128    3'h5
`define LMF_HF_DIV256    3'h6
`define LMF_DIV32_M1     8'h1f
`define LMF_DIV64_M1     8'h3f
`define LMF_DIV128_M1    8'h7f
`define LMF_DIV256_M1    8'hff

// ****************************************************************
// Base rate: reference ticks per common slot, minus one
// ****************************************************************
`define LMF_LF_128HZ     2'h1
`define LMF_LF_170HZ     2'h2
`define LMF_LF_256HZ     2'h0
`define LMF_SLOT_128HZ   6'h1f
`define LMF_SLOT_170HZ   6'h17
`define LMF_SLOT_256HZ   6'h0f
`define LMF_SLOT_512HZ   6'h07

// ****************************************************************
// Matrix geometry
// ****************************************************************
`define LMF_SEG_N        56
`define LMF_SEG_N_WIDE   48
`define LMF_COM_N        16
`define LMF_RAM_BYTES    128
`define LMF_SEG_FIRST_W  6'h08
`define LMF_LAST_ROW8    4'h7
`define LMF_LAST_ROW11   4'ha
`define LMF_LAST_ROW16   4'hf
`define LMF_ROW11_PG2MAX 3'h2

`endif

// file: inc/lmf_pkg.sv
// Types shared by the LCD frame timing block
package lmf_pkg;
  `include "lmf_cfg.svh"

  // Multiplex ratio decoded from the mode register
  typedef enum logic [1:0] {LMF_MUX8, LMF_ELEVEN_ROW_SELECT, LMF_SIXTEEN_ROW_SELECT, LMF_MUX_RSV} lmf_mux_t;

  // Frame engine state
  typedef enum logic {LMF_OFF, LMF_RUN} lmf_run_t;

  // Whole state of the top module apart from the display RAM
  typedef struct packed {
    logic [7:0]             mode;
    logic                   page;
    logic [2:0]             hf_act;
    lmf_mux_t               mux_act;
    logic [1:0]             lf_act;
    lmf_run_t               run;
    logic [3:0]             row;
    logic [5:0]             slot;
    logic [`LMF_COM_N-1:0]  com;
    logic [`LMF_SEG_N-1:0]  seg;
    logic                   hreadyout;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic                   dp_wr;
    logic [`LMF_IDX_W-1:0]  dp_idx;
  } lmf_top_st_t;

  // Whole state of the reference tick generator
  typedef struct packed {
    logic [7:0] cnt;
    logic       aux_prev;
    logic       tick;
  } lmf_tick_st_t;
endpackage

// file: rtl/lmf_lcd_timing.sv
// Multiplexed LCD frame timing, display RAM and mode register
//
// Functional notes
// RULE1 - Two select bits pick 1/8, 1/11 or 1/16 commons; both set reserved.
// RULE2 - Base frame rate code 01=128, 10=170, 00=256, 11=512 Hz.
// RULE3 - Frame rate scales by 8 over the number of commons.
// RULE4 - Each display RAM bit drives one dot; one is on.
// RULE5 - Two 64-byte RAM pages at indices 00 to 3F, chosen by page.
// RULE6 - 1/8 mode shows only page one as 56 by 8.
// RULE7 - 1/16 mode shows both pages as 48 by 16, skipping bytes 00-07.
// RULE8 - 1/11 mode: 48 by 11, skip bytes 00-07 and page-two bits 3-7.
// RULE9 - Bytes 38 to 3F of both pages are never displayed.
// RULE10 - Reset clears the mode register, display off; RAM stays undefined.
// RULE11 - STOP with internal clock source turns the display off, lines low.
// RULE12 - STOP with auxiliary oscillator selected keeps the display running.
// RULE13 - Source change applies at frame end; software must wait before STOP.
// RULE14 - Source 0 off, 1 auxiliary, 2 and 7 reserved, others divide.
// RULE15 - Mode layout: mux 7-6, source 5-3, bit 2 reserved, rate 1-0.
// RULE16 - Codes 011,100,101,110 divide the core clock by 32,64,128,256.
// RULE17 - Commons 1-8 from page one bits, 9-16 from page two bits.
// RULE18 - Each active common is driven once per frame for an equal slot.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module lmf_lcd_timing
  import lmf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  hsel,
  input  wire logic [ADDR_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  stop_in,
  input  wire logic                  auxiliary_low_oscillator,
  output logic [`LMF_SEG_N-1:0]      segment_lines,
  output logic [`LMF_COM_N-1:0]      common_lines
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The register map needs twelve address bits at least
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_chk
    $error("lmf_lcd_timing: ADDR_W must lie between 12 and 32");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  lmf_top_st_t            st_r;
  lmf_top_st_t            st_nxt;
  logic [7:0]             ram_mem [0:`LMF_RAM_BYTES-1];
  logic                   ram_we;
  logic [6:0]             ram_waddr;
  logic                   ref_tick;
  logic                   src_live;
  logic                   acc;
  logic                   hit;
  logic [`LMF_IDX_W-1:0]  idx;
  logic [7:0]             ram_rd;
  logic [7:0]             ram_mem_rd;

  // ****************************************************************
  // Decoding functions
  // ****************************************************************
  // Multiplex ratio from the two select bits
  function automatic lmf_mux_t mux_decode(input logic [7:0] mode);
    logic m11;
    logic m16;
    m11 = mode[`LMF_BIT_ELEVEN_ROW_SELECT];
    m16 = mode[`LMF_BIT_SIXTEEN_ROW_SELECT];
    unique case ({m16, m11})
      2'b00:   mux_decode = LMF_MUX8;   // RULE1
      2'b01:   mux_decode = LMF_ELEVEN_ROW_SELECT;  // RULE1
      2'b10:   mux_decode = LMF_SIXTEEN_ROW_SELECT;  // RULE1
      default: mux_decode = LMF_MUX_RSV;
    endcase
  endfunction

  // Clock source field of the mode register
  function automatic logic [2:0] hf_field(input logic [7:0] mode);
    hf_field = mode[`LMF_HF_HI:`LMF_HF_LO];  // RULE15
  endfunction

  // Base rate field of the mode register
  function automatic logic [1:0] lf_field(input logic [7:0] mode);
    lf_field = mode[`LMF_LF_HI:`LMF_LF_LO];  // RULE15
  endfunction

  // True for a source that can clock the display at all
  function automatic logic hf_usable(input logic [2:0] hf);
    unique case (hf)
      `LMF_HF_AUX, `LMF_HF_DIV32, `LMF_HF_DIV64,
      `LMF_HF_DIV128, `LMF_HF_DIV256: hf_usable = 1'b1;  // RULE14
      default:                        hf_usable = 1'b0;  // RULE14
    endcase
  endfunction

  // A source still runs in STOP only if it is the auxiliary one
  function automatic logic hf_live(input logic [2:0] hf, input logic stop);
    hf_live = hf_usable(hf) && (hf == `LMF_HF_AUX || !stop);  // RULE11 RULE12
  endfunction

  // Reference ticks per common slot, minus one; a frame spans eight slots at 1/8
  function automatic logic [5:0] slot_len(input logic [1:0] lf);
    unique case (lf)
      `LMF_LF_128HZ: slot_len = `LMF_SLOT_128HZ;  // RULE2
      `LMF_LF_170HZ: slot_len = `LMF_SLOT_170HZ;  // RULE2
      `LMF_LF_256HZ: slot_len = `LMF_SLOT_256HZ;  // RULE2
      default:       slot_len = `LMF_SLOT_512HZ;  // RULE2
    endcase
  endfunction

  // Last common of a frame; more commons stretch the frame
  function automatic logic [3:0] last_row(input lmf_mux_t mux);
    unique case (mux)
      LMF_MUX8:  last_row = `LMF_LAST_ROW8;   // RULE3
      LMF_ELEVEN_ROW_SELECT: last_row = `LMF_LAST_ROW11;  // RULE3
      default:   last_row = `LMF_LAST_ROW16;  // RULE3
    endcase
  endfunction

  // Segment pattern of one common row, gathered from the RAM bits
  function automatic logic [`LMF_SEG_N-1:0] row_seg(input logic [3:0] row, input lmf_mux_t mux);
    logic [`LMF_SEG_N-1:0] v;
    logic [5:0]            col;
    v = '0;
    for (int k = 0; k < `LMF_SEG_N; k++) begin
      if (mux == LMF_MUX8) begin
        col  = 6'(k);
        v[k] = ram_mem[{1'b0, col}][row[2:0]];                   // RULE6 RULE4
      end else if (k < `LMF_SEG_N_WIDE) begin
        col = 6'(k) + `LMF_SEG_FIRST_W;                          // RULE7 RULE9
        if (mux == LMF_ELEVEN_ROW_SELECT && row[3] && row[2:0] > `LMF_ROW11_PG2MAX) begin
          v[k] = 1'b0;                                           // RULE8
        end else begin
          v[k] = ram_mem[{row[3], col}][row[2:0]];               // RULE17 RULE4
        end
      end
    end
    return v;
  endfunction

  // ****************************************************************
  // Reference tick
  // ****************************************************************
  // Only the active source feeds the divider; a pending change waits
  lmf_ref_tick u_ref_tick (
    .ref_clk                  (ref_clk),
    .arst_n                   (arst_n),
    .hf_sel                   (st_r.hf_act),
    .enable                   (src_live),
    .auxiliary_low_oscillator (auxiliary_low_oscillator),
    .ref_tick                 (ref_tick)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Address phase accepted only with hready high
  assign acc = hsel && htrans[1] && hready;
  assign idx = haddr[`LMF_ADDR_MSB:`LMF_ADDR_LSB];
  assign hit = (ADDR_W == 12) ? 1'b1 : ((haddr >> 12) == '0);

  // Display RAM read; a write still in its data phase is forwarded
  assign ram_mem_rd = ram_mem[{st_nxt.page, idx[5:0]}];
  always_comb begin
    ram_rd = ram_mem_rd;
    if (ram_we && ram_waddr == {st_nxt.page, idx[5:0]}) begin
      ram_rd = hwdata[7:0];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt           = st_r;
    ram_we           = 1'b0;
    ram_waddr        = {st_r.page, st_r.dp_idx[5:0]};
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp     = 1'b0;
    st_nxt.hrdata    = 32'h0000_0000;

    // Data phase of a write; bit 2 of the mode register stays zero
    if (st_r.dp_wr) begin
      if (st_r.dp_idx <= `LMF_IDX_RAM_LAST) begin
        ram_we = 1'b1;                                           // RULE5
      end else if (st_r.dp_idx == `LMF_IDX_MODE) begin
        st_nxt.mode = hwdata[7:0] & `LMF_MODE_MASK;              // RULE15
      end else if (st_r.dp_idx == `LMF_IDX_PAGE) begin
        st_nxt.page = hwdata[0];                                 // RULE5
      end
    end

    // Address phase: capture write target, prepare read data
    st_nxt.dp_wr  = acc && hwrite && hit;
    st_nxt.dp_idx = idx;
    if (acc && !hwrite && hit) begin
      if (idx <= `LMF_IDX_RAM_LAST) begin
        st_nxt.hrdata = {24'h00_0000, ram_rd};                   // RULE5
      end else if (idx == `LMF_IDX_MODE) begin
        st_nxt.hrdata = {24'h00_0000, st_nxt.mode};
      end else if (idx == `LMF_IDX_PAGE) begin
        st_nxt.hrdata = {31'h0000_0000, st_nxt.page};
      end else if (idx == `LMF_IDX_STATUS) begin
        st_nxt.hrdata = {9'h000, stop_in, st_r.row, st_r.lf_act, st_r.mux_act,
                         st_r.hf_act, 4'h0, st_r.slot, st_r.run == LMF_RUN};
      end
    end

    // Frame engine
    if (st_r.run == LMF_OFF) begin
      // Idle: no frame in progress, so a valid setting starts at once
      if (hf_live(hf_field(st_r.mode), stop_in) && mux_decode(st_r.mode) != LMF_MUX_RSV) begin
        st_nxt.run     = LMF_RUN;
        st_nxt.hf_act  = hf_field(st_r.mode);
        st_nxt.mux_act = mux_decode(st_r.mode);
        st_nxt.lf_act  = lf_field(st_r.mode);
        st_nxt.row     = 4'h0;
        st_nxt.slot    = slot_len(lf_field(st_r.mode));
      end
    end else if (!src_live) begin
      // Core clock gone in STOP: drop everything to ground
      st_nxt.run    = LMF_OFF;                                   // RULE11 RULE13
      st_nxt.hf_act = `LMF_HF_OFF;
    end else if (ref_tick) begin
      if (st_r.slot != 6'h00) begin
        st_nxt.slot = st_r.slot - 6'h01;                         // RULE18
      end else if (st_r.row != last_row(st_r.mux_act)) begin
        st_nxt.row  = st_r.row + 4'h1;                           // RULE18
        st_nxt.slot = slot_len(st_r.lf_act);
      end else begin
        // Frame boundary: only here does a new setting take hold
        st_nxt.hf_act  = hf_field(st_r.mode);                    // RULE13
        st_nxt.mux_act = mux_decode(st_r.mode);                  // RULE13
        st_nxt.lf_act  = lf_field(st_r.mode);
        st_nxt.row     = 4'h0;
        st_nxt.slot    = slot_len(lf_field(st_r.mode));
        if (!hf_live(hf_field(st_r.mode), stop_in) || mux_decode(st_r.mode) == LMF_MUX_RSV) begin
          st_nxt.run    = LMF_OFF;                               // RULE14
          st_nxt.hf_act = `LMF_HF_OFF;
        end
      end
    end

    // Line drive; pattern follows RAM contents live within a slot
    if (st_nxt.run == LMF_RUN) begin
      st_nxt.com = `LMF_COM_N'(1) << st_nxt.row;                 // RULE18
      st_nxt.seg = row_seg(st_nxt.row, st_nxt.mux_act);          // RULE4
    end else begin
      st_nxt.com = '0;                                           // RULE11
      st_nxt.seg = '0;                                           // RULE11
    end
  end

  // Reference clock alive for the active source
  assign src_live = hf_live(st_r.hf_act, stop_in);

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Mode cleared at reset, so the display starts dark
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r           <= '0;
      st_r.mode      <= `LMF_MODE_RST;                           // RULE10
      st_r.run       <= LMF_OFF;                                 // RULE10
      st_r.hreadyout <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Display RAM has no reset; contents are arbitrary after power up
  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      ram_mem[ram_waddr] <= hwdata[7:0];                         // RULE10
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hreadyout     = st_r.hreadyout;
  assign hresp         = st_r.hresp;
  assign hrdata        = st_r.hrdata;
  assign segment_lines = st_r.seg;
  assign common_lines  = st_r.com;

endmodule

// file: rtl/lmf_ref_tick.sv
// Reference tick generator: divided core clock or auxiliary oscillator
`timescale 1ns/1ps
module lmf_ref_tick
  import lmf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] hf_sel,
  input  wire logic       enable,
  input  wire logic       auxiliary_low_oscillator,
  output logic            ref_tick
);

  lmf_tick_st_t st_r;
  lmf_tick_st_t st_nxt;

  // Divisor minus one for the internal source codes
  function automatic logic [7:0] div_m1(input logic [2:0] hf);
    unique case (hf)
      `LMF_HF_DIV32:  div_m1 = `LMF_DIV32_M1;
      `LMF_HF_DIV64:  div_m1 = `LMF_DIV64_M1;
      `LMF_HF_DIV128: div_m1 = `LMF_DIV128_M1;
      default:        div_m1 = `LMF_DIV256_M1;
    endcase
  endfunction

  // One tick per reference period; rising edge of the slow oscillator
  always_comb begin
    st_nxt          = st_r;
    st_nxt.tick     = 1'b0;
    st_nxt.aux_prev = auxiliary_low_oscillator;
    if (!enable) begin
      st_nxt.cnt = 8'h00;
    end else if (hf_sel == `LMF_HF_AUX) begin
      st_nxt.cnt  = 8'h00;
      st_nxt.tick = auxiliary_low_oscillator && !st_r.aux_prev; // RULE12
    end else if (st_r.cnt >= div_m1(hf_sel)) begin
      st_nxt.cnt  = 8'h00;                                       // RULE16
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ref_tick = st_r.tick;

endmodule

// file: testbench/lmf_glass_model.sv
// Behavioural LCD glass: records the dots of each row and the row slot length
`timescale 1ns/1ps
`include "lmf_cfg.svh"
module lmf_glass_model
  import lmf_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  clr,
  input  wire logic [`LMF_SEG_N-1:0] segment_lines,
  input  wire logic [`LMF_COM_N-1:0] common_lines,
  output logic [`LMF_SEG_N-1:0]      dots [`LMF_COM_N],
  output logic [`LMF_COM_N-1:0]      seen,
  output int                         last_slot
);
  logic [`LMF_COM_N-1:0] com_q = '0;
  int                    cnt   = 0;

  // A dot is lit while its common is active and its segment is high
  always @(posedge ref_clk) begin
    for (int r = 0; r < `LMF_COM_N; r++) begin
      if (common_lines[r]) begin
        dots[r] <= segment_lines;
      end
    end
    seen  <= clr ? '0 : seen | common_lines;
    com_q <= common_lines;
    // Slot measured only between two lit rows, so start and stop do not count
    if (common_lines != com_q) begin
      if (common_lines != '0 && com_q != '0) begin
        last_slot <= cnt;
      end
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// file: testbench/lmf_lcd_timing_properties.sv
// Port checker of the LCD frame timing block, bound to its top
`timescale 1ns/1ps
`include "lmf_cfg.svh"
module lmf_lcd_timing_checker
  import lmf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic                  ref_clk,
  input wire logic                  arst_n,
  input wire logic                  hsel,
  input wire logic [ADDR_W-1:0]     haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic                  stop_in,
  input wire logic                  auxiliary_low_oscillator,
  input wire logic [`LMF_SEG_N-1:0] segment_lines,
  input wire logic [`LMF_COM_N-1:0] common_lines
);
  logic       dp_r, dp_wr_r, dp_mode_r, wide_r, on_r, settled_r, row0_was_r;
  logic [2:0] src_r;

  // Bus phase tracking; settled only once a frame start follows the last mode write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_r       <= 1'b0;
      dp_wr_r    <= 1'b0;
      dp_mode_r  <= 1'b0;
      wide_r     <= 1'b0;
      on_r       <= 1'b0;
      settled_r  <= 1'b1;
      row0_was_r <= 1'b0;
      src_r      <= 3'h0;
    end else begin
      dp_r       <= hsel && htrans[1] && hready;
      dp_wr_r    <= hwrite;
      dp_mode_r  <= haddr[11:2] == `LMF_IDX_MODE;
      row0_was_r <= common_lines[0];
      if (dp_r && dp_wr_r && dp_mode_r) begin
        wide_r    <= wide_r || (^hwdata[7:6]);
        on_r      <= on_r || hwdata[7:0] != 8'h00;
        src_r     <= hwdata[5:3];
        settled_r <= 1'b0;
      end else if (common_lines[0] && !row0_was_r) begin
        settled_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Row step: one lit common moves to another lit common
  sequence row_change_s;
    common_lines != 16'h0000 && $past(common_lines) != 16'h0000 && common_lines != $past(common_lines);
  endsequence
  sequence stop_hold_s;
    stop_in [*3];
  endsequence

  zero_wait_a: assert property (hreadyout)
    else $error("wait state inserted");
  okay_resp_a: assert property (!hresp)
    else $error("error response seen");
  idle_data_a: assert property (!(dp_r && !dp_wr_r) |-> hrdata == 32'h0)
    else $error("read data outside read data phase");
  mode_read_a: assert property (dp_r && !dp_wr_r && dp_mode_r |-> hrdata[31:8] == 24'h0 && !hrdata[2])
    else $error("mode read shows reserved bits");
  one_common_a: assert property ($onehot0(common_lines))
    else $error("more than one common active");
  row_order_a: assert property (row_change_s |-> common_lines == {$past(common_lines[14:0]), 1'b0}
    || common_lines == 16'h0001)
    else $error("common rows out of order");
  slot_hold_a: assert property (row_change_s |=> $stable(common_lines) [*8])
    else $error("common slot too short");
  reset_dark_a: assert property (!on_r |-> common_lines == 16'h0 && segment_lines == '0)
    else $error("display lit before mode set");
  eight_rows_a: assert property (!wide_r |-> common_lines[15:8] == 8'h00)
    else $error("upper commons used in eight row mode");
  stop_dark_a: assert property (stop_hold_s ##0 (settled_r && src_r != `LMF_HF_AUX)
    |-> common_lines == 16'h0 && segment_lines == '0)
    else $error("lines driven during stop on internal clock");
endmodule

bind lmf_lcd_timing lmf_lcd_timing_checker #(.ADDR_W(ADDR_W)) u_lmf_lcd_timing_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .stop_in(stop_in), .auxiliary_low_oscillator(auxiliary_low_oscillator),
  .segment_lines(segment_lines), .common_lines(common_lines));

// file: testbench/test_lmf_lcd_timing.sv
// Self-checking bench of the LCD frame timing block
`timescale 1ns/1ps
`include "lmf_cfg.svh"
module test_lmf_lcd_timing;
  import lmf_pkg::*;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
  logic                  ref_clk, arst_n, hsel, hwrite, stop_in, aux_osc, clr, hreadyout, hresp;
  logic [11:0]           haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata, q;
  logic [`LMF_SEG_N-1:0] seg, exp_row;
  logic [`LMF_COM_N-1:0] com, seen, c0;
  logic [`LMF_SEG_N-1:0] dots [`LMF_COM_N];
  logic [7:0]            ram [2][64];
  logic [7:0]            mux_tab [3] = '{8'h1b, 8'h5b, 8'h9b};
  logic [7:0]            rate_tab [5] = '{8'h19, 8'h1a, 8'h18, 8'h23, 8'h2b};
  int                    slot_tab [5] = '{1024, 768, 512, 512, 1024};
  int                    last_slot, n_errors = 0, check_count = 0, aux_cnt = 0, pf;

  lmf_lcd_timing u_lmf_lcd_timing (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_in(stop_in),
    .auxiliary_low_oscillator(aux_osc), .segment_lines(seg), .common_lines(com));
  lmf_glass_model u_lmf_glass_model (.ref_clk(ref_clk), .clr(clr), .segment_lines(seg),
    .common_lines(com), .dots(dots), .seen(seen), .last_slot(last_slot));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Free running slow oscillator: one rising edge every 20 clocks
  always @(posedge ref_clk) begin
    aux_cnt <= aux_cnt == 9 ? 0 : aux_cnt + 1;
    if (aux_cnt == 9) begin
      aux_osc <= ~aux_osc;
    end
  end

  // One single AHB transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {idx, 2'h0};
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 200);
    q = hrdata;
    if (n >= 200) n_errors++;
  endtask

  task automatic settle(input int cyc);
    repeat (cyc) @(posedge ref_clk);
  endtask

  // Frame contents against the RAM image for mux 0 (1/8), 1 (1/11), 2 (1/16)
  task automatic chk_frame(input int mx);
    int rows;
    rows = mx == 0 ? 8 : (mx == 1 ? 11 : 16);
    for (int r = 0; r < 16; r++) begin
      for (int k = 0; k < 56; k++) begin
        if (mx == 0) exp_row[k] = ram[0][k][r % 8];
        else exp_row[k] = k < 48 ? ram[r / 8][k + 8][r % 8] : 1'b0;
      end
      `CHK("seen", r < rows, seen[r])
      if (r < rows) `CHK("row", exp_row, dots[r])
    end
    `CHK("slot", 256, last_slot)
  endtask

  task automatic results();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    results();
  end

  initial begin
    {arst_n, hsel, hwrite, stop_in, aux_osc, clr, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    bus(0, `LMF_IDX_MODE, 0);
    `CHK("mode_rst", 32'h0, q)
    `CHK("com_rst", 16'h0, com)
    bus(1, `LMF_IDX_MODE, 32'hff);
    bus(0, `LMF_IDX_MODE, 0);
    `CHK("mode_rw", 32'hfb, q)
    bus(0, 10'h3ff, 0);
    `CHK("unmapped", 32'h0, q)
    settle(100);
    `CHK("rsv_off", 16'h0, com)
    bus(1, `LMF_IDX_MODE, 32'h13);
    settle(600);
    `CHK("src2_off", 16'h0, com)
    // Fill both pages with distinct images, then read one byte back from each
    for (int p = 0; p < 2; p++) begin
      bus(1, `LMF_IDX_PAGE, p);
      for (int k = 0; k < 64; k++) begin
        ram[p][k] = 8'(k * 37) ^ (p != 0 ? 8'hc3 : 8'h5a);
        bus(1, 10'(k), {24'h0, ram[p][k]});
      end
    end
    bus(0, 10'h005, 0);
    `CHK("page2", {24'h0, ram[1][5]}, q)
    bus(1, `LMF_IDX_PAGE, 0);
    bus(0, 10'h005, 0);
    `CHK("page1", {24'h0, ram[0][5]}, q)
    // Each multiplex ratio at div32 and the fastest base rate
    for (int m = 0; m < 3; m++) begin
      bus(1, `LMF_IDX_MODE, {24'h0, mux_tab[m]});
      settle(4200);
      clr <= 1'b1;
      settle(1);
      clr <= 1'b0;
      settle(4400);
      chk_frame(m);
    end
    // Base rates and divisors in 1/8 mode; a change waits for the frame end
    pf = 4096;
    for (int i = 0; i < 5; i++) begin
      bus(1, `LMF_IDX_MODE, {24'h0, rate_tab[i]});
      settle(pf + 3 * slot_tab[i]);
      `CHK("slot", slot_tab[i], last_slot)
      pf = 8 * slot_tab[i];
    end
    bus(1, `LMF_IDX_MODE, 32'h0b);
    settle(pf + 480);
    `CHK("aux_slot", 160, last_slot)
    stop_in <= 1'b1;
    c0 = com;
    settle(200);
    `CHK("stop_aux", 1'b1, com != c0 && com != 16'h0)
    stop_in <= 1'b0;
    bus(1, `LMF_IDX_MODE, 32'h1b);
    settle(100);
    `CHK("pending", 160, last_slot)
    settle(8 * 160 + 3 * 256);
    `CHK("new_src", 256, last_slot)
    bus(0, `LMF_IDX_STATUS, 0);
    `CHK("status", 32'h0003_1801, q & 32'h0003_f801)
    stop_in <= 1'b1;
    settle(4);
    `CHK("stop_com", 16'h0, com)
    `CHK("stop_seg", 56'h0, seg)
    stop_in <= 1'b0;
    results();
  end
endmodule
